/* ptim_assertions.sv */
`timescale 1ns/1ns
// watches the bus and irq pins of the tick timer
module ptim_assertions
   import ptim_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic dbg_halt,
   input wire logic irq
);
   // single domain, reset silences everything
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire req = read | write; // any pending request
   chk_one_wait: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_ack_fixed: assert property (req && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait state");
   chk_no_spont: assert property (!req && waitrequest |=> waitrequest)
      else $error("answer without a request");
   chk_unmap_zero: assert property (read && waitrequest && address > OFS_EVENT_MASK |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_wr_zero: assert property (write && waitrequest |=> readdata == 32'h0)
      else $error("write returned nonzero data");
   // first edge after reset still sees old data, hence the past guard
   chk_rd_hold: assert property (waitrequest && $past(arst_n) |-> $stable(readdata))
      else $error("readdata moved outside an answer");
   chk_halt_irq: assert property (dbg_halt && $past(dbg_halt) && !write && !$past(write) |=> !$rose(irq))
      else $error("interrupt raised while halted");
   chk_irq_hold: assert property (irq && !req && !$past(req) |=> irq)
      else $error("interrupt dropped without an access");
   cover property (read && waitrequest && address == OFS_INTERVAL_VALUE_ACK);
   cover property ($rose(irq));
   cover property (dbg_halt && read && waitrequest);
endmodule // ptim_assertions

bind ptim_top ptim_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .dbg_halt(dbg_halt), .irq(irq));

/* ptim_pkg.sv */
// shared constants and carriers of the interval tick timer
package ptim_pkg;

   // counter widths and prescaler
   localparam int unsigned CNT_W = 20;
   localparam int unsigned TALLY_W = 12;
   localparam int unsigned PRESCALE_DIV = 16;
   localparam int unsigned PRESCALE_W = $clog2(PRESCALE_DIV);
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 4'hF;

   // bus geometry
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned EVT_W = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INTERVAL_MODE = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL_STATUS = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL_VALUE_ACK = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL_VALUE_SNAPSHOT = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 5'h14;

   // field positions
   localparam int unsigned MODE_LIMIT_LSB = 0;
   localparam int unsigned MODE_ON_BIT = 24;
   localparam int unsigned MODE_IRQ_EN_BIT = 25;
   localparam int unsigned VALUE_TALLY_LSB = 20;
   localparam int unsigned STATUS_FLAG_BIT = 0;
   localparam int unsigned EVT_INTERVAL_BIT = 0;
   localparam int unsigned EVT_TALLY_WRAP_BIT = 1;

   // reset values
   localparam logic [DATA_W-1:0] MODE_RESET = 32'h000F_FFFF;
   localparam logic [EVT_W-1:0] EVT_MASK_RESET = 2'h0;

   // bus phase, gray order idle -> ack
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } ptim_bus_e;

   // software-visible mode fields
   typedef struct packed {
      logic irq_en;
      logic on;
      logic [CNT_W-1:0] limit;
   } ptim_mode_s;

   // whole state of the timer
   typedef struct packed {
      ptim_bus_e bus;
      logic waitreq;
      logic [DATA_W-1:0] rdata;
      ptim_mode_s mode;
      logic [PRESCALE_W-1:0] prescale;
      logic [CNT_W-1:0] interval_count;
      logic [TALLY_W-1:0] overflow_tally;
      logic interval_reached_flag;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] evt_mask;
      logic irq;
   } ptim_state_s;

endpackage

/* ptim_tb.sv */
`timescale 1ns/1ns
module tb
   import ptim_pkg::*;
;
   logic sys_clk, arst_n, read, write, dbg_halt, waitrequest, irq;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] writedata, readdata, s, q, a;
   logic [3:0] byteenable; // all lanes, word writes only
   logic [4:0] adr [4] = '{5'h04, 5'h08, 5'h0C, 5'h18}; // last one unmapped
   int n_errors, total_checks, k, lim, w;

   ptim_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .dbg_halt(dbg_halt), .irq(irq));

   // 20 MHz
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // one avalon access; held until waitrequest is seen low
   task automatic acc(input logic w, input logic [4:0] ad, input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      read <= !w;
      write <= w;
      address <= ad;
      writedata <= d;
      // look between edges, so the flop update at an edge cannot race the test
      do @(negedge sys_clk); while (waitrequest !== 1'b0);
      r = readdata;
      // the edge that samples waitrequest low ends the access
      @(posedge sys_clk);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] ad, input logic [31:0] d);
      logic [31:0] r;
      acc(1'b1, ad, d, r);
   endtask

   // irq is registered, so let two edges land first
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // tally sits above the count, so k intervals add k << 20
   function automatic logic [31:0] plus(input logic [31:0] v, input int n);
      return v + (32'(n) << 20);
   endfunction

   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the planned run
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      wrap_up();
   end

   initial begin
      {read, write, dbg_halt, arst_n} = 4'h0;
      address = 5'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      void'($urandom(32'h4B608734));
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      acc(0, OFS_INTERVAL_MODE, 0, q);
      chk(q, MODE_RESET);
      repeat (40) @(posedge sys_clk);
      // timer off after reset: counters must stay zero
      for (int i = 0; i < 4; i++) begin
         acc(0, adr[i], 0, q);
         chk(q, 32'h0);
      end
      wr(OFS_INTERVAL_MODE, 32'hFEFF_FFFF);
      acc(0, OFS_INTERVAL_MODE, 0, q);
      chk(q, 32'h020F_FFFF);
      wr(OFS_INTERVAL_STATUS, 32'hFFFF_FFFF); // read-only, ignored
      acc(0, OFS_INTERVAL_STATUS, 0, q);
      chk(q, 32'h0);
      // limit change in mid-count: 48 cycles apart means 3 ticks
      wr(OFS_INTERVAL_MODE, 32'h0100_0040);
      repeat (32) @(posedge sys_clk);
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, s);
      wr(OFS_INTERVAL_MODE, 32'h0100_0030);
      repeat (42) @(posedge sys_clk);
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, q);
      chk(q, s + 32'h3);
      // switch off: finishes the interval, one hit, then parked at zero
      wr(OFS_INTERVAL_MODE, 32'h0000_0030);
      repeat (900) @(posedge sys_clk);
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, s);
      repeat (61) @(posedge sys_clk);
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, q);
      chk(s, 32'h0010_0000);
      chk(q, s);
      acc(0, OFS_INTERVAL_STATUS, 0, q);
      chk(q, 32'h1);
      ck_irq(1'b0);
      // event status, mask and one-to-clear
      acc(0, OFS_EVENT_STATUS, 0, q);
      chk(q, 32'h1);
      wr(OFS_EVENT_MASK, 32'h1);
      ck_irq(1'b1);
      wr(OFS_EVENT_STATUS, 32'h1);
      acc(0, OFS_EVENT_STATUS, 0, q);
      chk(q, 32'h0);
      ck_irq(1'b0);
      wr(OFS_EVENT_MASK, 32'h0);
      acc(0, OFS_INTERVAL_VALUE_ACK, 0, q);
      chk(q, 32'h0010_0000);
      acc(0, OFS_INTERVAL_STATUS, 0, q);
      chk(q, 32'h0);
      // running: zero limit corner, then a random one
      for (int i = 0; i < 2; i++) begin
         lim = i ? $urandom_range(6, 1) : 0;
         k = $urandom_range(3, 1);
         w = k * PRESCALE_DIV * (lim + 1);
         wr(OFS_INTERVAL_MODE, 32'h0300_0000 | lim);
         repeat (w) @(posedge sys_clk);
         acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, s);
         repeat (w - 3) @(posedge sys_clk);
         acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, q);
         chk(q, plus(s, k));
         repeat (w - 3) @(posedge sys_clk);
         acc(0, OFS_INTERVAL_VALUE_ACK, 0, a);
         chk(a, plus(q, k));
         repeat (w - 3) @(posedge sys_clk);
         acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, q);
         chk(q, plus({12'h0, a[19:0]}, k));
         acc(0, OFS_INTERVAL_STATUS, 0, q);
         chk(q, 32'h1);
         ck_irq(1'b1);
      end
      // debug halt freezes both counters
      @(posedge sys_clk);
      dbg_halt <= 1'b1;
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, s);
      repeat (100) @(posedge sys_clk);
      acc(0, OFS_INTERVAL_VALUE_SNAPSHOT, 0, q);
      chk(q, s);
      dbg_halt <= 1'b0;
      wrap_up();
   end
endmodule // tb

/* ptim_top.sv */
`timescale 1ns/1ns

// Operation
// - 20-bit interval, 12-bit overflow counters, clock/16
// - interval counts up, wraps at limit, bumps tally
// - limit hit sets flag; flag irq needs enable, masked events need none
// - period equals limit plus one ticks
// - limit write never restarts either counter
// - ack read returns counters, clears tally, flag
// - snapshot read returns counters, no side effects
// - timer_on resets low; acts only at zero
// - cleared timer_on finishes interval, then stops
// - debug halt freezes both counters
// - mode: limit 19:0, on 24, irq 25
// - limit compared against full 20-bit count
// - value words: count 19:0, tally 31:20
// - status bit0 flag held until ack read
module ptim_top
   import ptim_pkg::*;
(
   input wire logic sys_clk, // system clock, 20 MHz
   input wire logic arst_n, // async reset, low active
   input wire logic [ADDR_W-1:0] address, // byte address
   input wire logic read, // avalon read request
   input wire logic write, // avalon write request
   input wire logic [DATA_W-1:0] writedata, // write data
   input wire logic [3:0] byteenable, // write byte lanes
   output logic [DATA_W-1:0] readdata, // read data, registered
   output logic waitrequest, // stall, registered
   input wire logic dbg_halt, // core in debug state
   output logic irq // level interrupt, registered
);

   // the whole block is one state struct:
   // one always_comb computes the next copy,
   // one always_ff registers it, nothing else
   // holds state, so reset covers every flop
   // present and next state
   ptim_state_s s_q;
   ptim_state_s s_d;

   // waitrequest sits high in reset and idle,
   // so a master never sees a stray answer
   // mode fields start at limit all ones, off
   // reset image of the whole state
   localparam ptim_state_s STATE_RESET = '{
      bus: BUS_IDLE,
      waitreq: 1'b1,
      rdata: '0,
      mode: ptim_mode_s'(MODE_RESET[CNT_W+1:0]),
      prescale: '0,
      interval_count: '0,
      overflow_tally: '0,
      interval_reached_flag: 1'b0,
      evt: '0,
      evt_mask: EVT_MASK_RESET,
      irq: 1'b0
   };

   // lanes with byteenable low keep old bytes;
   // used for mode and mask writes alike
   // byte lane merge of a write into an old word
   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [3:0] be
   );
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // both value words must match bit for bit,
   // so one function packs them; any change
   // to the layout lands in both at once
   // packing shared by ack and snapshot words
   function automatic logic [DATA_W-1:0] value_word(
      input logic [CNT_W-1:0] cnt,
      input logic [TALLY_W-1:0] tally
   );
      logic [DATA_W-1:0] w;
      w = '0;
      w[CNT_W-1:0] = cnt;
      w[VALUE_TALLY_LSB +: TALLY_W] = tally;
      return w;
   endfunction

   // also the old word of a lane merged write
   // mode fields back to a bus word, reserved bits zero
   function automatic logic [DATA_W-1:0] mode_word(input ptim_mode_s m);
      logic [DATA_W-1:0] w;
      w = '0;
      w[MODE_LIMIT_LSB +: CNT_W] = m.limit;
      w[MODE_ON_BIT] = m.on;
      w[MODE_IRQ_EN_BIT] = m.irq_en;
      return w;
   endfunction

   // low event bits of a bus word
   function automatic logic [EVT_W-1:0] evt_bits(input logic [DATA_W-1:0] w);
      return w[EVT_W-1:0];
   endfunction

   // order inside the process matters:
   // bus decode first, then register writes,
   // then prescaler and counters, then flags,
   // and the interrupt last, from the next state,
   // so irq follows its cause by one edge only
   // next state of everything
   always_comb begin
      logic take; // request accepted this cycle
      logic rd_ack; // acknowledging value read
      logic wr_mode; // mode register write
      logic wr_evt; // event status write
      logic wr_mask; // event mask write
      logic tick; // one prescaled counting tick
      logic active; // interval counter may advance
      logic hit; // interval completed this tick
      logic tally_wrap; // overflow tally rolls over
      logic [DATA_W-1:0] merged; // byte merged write word
      logic [EVT_W-1:0] evt_set; // events raised now
      logic [EVT_W-1:0] evt_clr; // events cleared by software
      logic [DATA_W-1:0] rword; // read data of this access
      take = 1'b0;
      rd_ack = 1'b0;
      wr_mode = 1'b0;
      wr_evt = 1'b0;
      wr_mask = 1'b0;
      tick = 1'b0;
      active = 1'b0;
      hit = 1'b0;
      tally_wrap = 1'b0;
      merged = '0;
      evt_set = '0;
      evt_clr = '0;
      rword = '0;
      s_d = s_q;

      // fixed latency keeps the master simple:
      // accept at one edge, answer the next cycle,
      // back to idle after that; a request still
      // high during the answer is not taken twice,
      // since the phase is not idle then
      // bus handshake: one wait cycle, then the answer
      case (s_q.bus)
         BUS_IDLE: begin
            // accept a request, drop waitrequest next cycle
            if (read || write) begin
               take = 1'b1;
               s_d.bus = BUS_ACK;
               s_d.waitreq = 1'b0;
            end
         end
         BUS_ACK: begin
            // master samples waitrequest low here and releases
            s_d.bus = BUS_IDLE;
            s_d.waitreq = 1'b1;
         end
         default: begin
            s_d.bus = BUS_IDLE;
            s_d.waitreq = 1'b1;
         end
      endcase

      // side effects happen at the accepting edge;
      // readdata then stands until the next access
      // full address decode, no aliasing
      // address decode of an accepted request
      if (take && read) begin
         case (address)
            OFS_INTERVAL_MODE: begin
               rword = mode_word(s_q.mode);
            end
            OFS_INTERVAL_STATUS: begin
               rword[STATUS_FLAG_BIT] = s_q.interval_reached_flag;
            end
            OFS_INTERVAL_VALUE_ACK: begin
               // counters as they stand, then acknowledge
               rword = value_word(s_q.interval_count, s_q.overflow_tally);
               rd_ack = 1'b1;
            end
            OFS_INTERVAL_VALUE_SNAPSHOT: begin
               // same word, no side effect at all
               rword = value_word(s_q.interval_count, s_q.overflow_tally);
            end
            OFS_EVENT_STATUS: begin
               rword[EVT_W-1:0] = s_q.evt;
            end
            OFS_EVENT_MASK: begin
               rword[EVT_W-1:0] = s_q.evt_mask;
            end
            default: begin
               // unmapped reads answer zero
               rword = '0;
            end
         endcase
         s_d.rdata = rword;
      end else if (take) begin
         // writes read back zero
         s_d.rdata = '0;
      end

      // interval status and value words are read-only:
      // writes there are dropped without error
      // write decode, unmapped and read-only targets ignored
      if (take && write) begin
         case (address)
            OFS_INTERVAL_MODE: begin
               wr_mode = 1'b1;
            end
            OFS_EVENT_STATUS: begin
               wr_evt = 1'b1;
            end
            OFS_EVENT_MASK: begin
               wr_mask = 1'b1;
            end
            default: begin
               wr_mode = 1'b0;
            end
         endcase
      end

      // a new limit acts at the next compare;
      // timer_on takes effect once the count is zero
      // counters and prescaler phase untouched
      // mode write touches only the fields, never the counters
      if (wr_mode) begin
         merged = lane_merge(mode_word(s_q.mode), writedata, byteenable);
         s_d.mode.limit = merged[MODE_LIMIT_LSB +: CNT_W];
         s_d.mode.on = merged[MODE_ON_BIT];
         s_d.mode.irq_en = merged[MODE_IRQ_EN_BIT];
      end

      // event mask write
      if (wr_mask) begin
         merged = lane_merge({{(DATA_W-EVT_W){1'b0}}, s_q.evt_mask}, writedata, byteenable);
         s_d.evt_mask = evt_bits(merged);
      end

      // only lane 0 carries the clear bits
      // event status write: a one clears, zero keeps
      if (wr_evt && byteenable[0]) begin
         evt_clr = evt_bits(writedata);
      end

      // tick is one cycle wide, once per sixteen;
      // halting the phase too means a debug stop
      // costs no partial tick on resume
      // prescaler, frozen in debug so counting resumes in phase
      if (!dbg_halt) begin
         s_d.prescale = s_q.prescale + 1'b1;
         tick = (s_q.prescale == PRESCALE_LAST);
      end

      // a running count always finishes its interval,
      // so clearing timer_on never cuts a period short
      // timer_on only matters while the count is zero
      active = (s_q.interval_count != '0) || s_q.mode.on;

      // limit+1 ticks per interval, zero included;
      // a zero limit hits on every tick
      // interval counter, 0 .. limit inclusive
      if (tick && active) begin
         if (s_q.interval_count == s_q.mode.limit) begin
            s_d.interval_count = '0;
            hit = 1'b1;
         end else begin
            // a limit lowered below the count wraps via full range
            s_d.interval_count = s_q.interval_count + 1'b1;
         end
      end

      // no interval is lost to a racing ack read:
      // the hit lands in the fresh tally
      // overflow tally: ack clears first, a hit this cycle still counts
      s_d.overflow_tally = rd_ack ? '0 : s_q.overflow_tally;
      if (hit) begin
         tally_wrap = (s_d.overflow_tally == '1);
         s_d.overflow_tally = s_d.overflow_tally + 1'b1;
      end

      // only an ack read clears it; snapshot reads do not
      // reached flag: set beats the clearing read
      s_d.interval_reached_flag = (s_q.interval_reached_flag && !rd_ack) || hit;

      // bit1 warns that the tally has wrapped
      // and so undercounts elapsed intervals
      // sticky event bits, set wins over clear
      evt_set[EVT_INTERVAL_BIT] = hit;
      evt_set[EVT_TALLY_WRAP_BIT] = tally_wrap;
      s_d.evt = (s_q.evt & ~evt_clr) | evt_set;

      // taken from the next state so the pin
      // is a plain flop with one edge of delay
      // one level interrupt from the flag and the masked events
      s_d.irq = (s_d.interval_reached_flag && s_d.mode.irq_en) || (|(s_d.evt & s_d.evt_mask));
   end

   // asynchronous reset loads constants only
   // state register
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // no logic between flop and pin, so
   // outputs carry no glitches or combinational paths
   // outputs straight from the state flops
   assign readdata = s_q.rdata;
   assign waitrequest = s_q.waitreq;
   assign irq = s_q.irq;

endmodule // ptim_top
